// ==== bench/mgmt_host_model.sv ====
// Host model: SPI master and I2C master, far side of the slave.
// SPI clock runs only inside frames; SDA is open drain, pulled up.
`timescale 1ns/1ps
module mgmt_host_model (
    output logic spiClk, // SPI clock
    output logic chipSelectLow, // SPI select
    output logic serialInLine, // SPI data to slave
    input wire logic serialOutLine, // SPI data from slave
    output logic sclLine, // I2C clock
    output logic sdaLow, // Host pulls SDA low
    input wire logic sdaIn // SDA wire level
);
    // Idle: clock low, select high
    initial {spiClk, chipSelectLow, serialInLine, sclLine, sdaLow} =
        5'h0A;
    // Whole frame, MSB first; TA bits are junk on purpose
    task automatic frame(input logic [26:0] hdr, input int n,
            input logic [15:0] wd, output logic [15:0] rd);
        logic [55:0] s;
        s = {hdr, 5'h15, wd, 8'h00};
        rd = 16'h0000;
        #62.5 chipSelectLow = 0;
        for (int i = 0; i < 32 + 8 * n; i++) begin
            serialInLine = s[55 - i];
            #62.5 spiClk = 1;
            if (i >= 32) rd = {rd[14:0], serialOutLine};
            #62.5 spiClk = 0;
        end
        #62.5 chipSelectLow = 1;
        serialInLine = !serialInLine; // Not the last value once idle
    endtask : frame
    task automatic i2c_bit(input logic b, output logic got);
        sdaLow = !b;
        #250 sclLine = 1;
        got = sdaIn;
        #500 sclLine = 0;
        #250;
    endtask : i2c_bit
    // Start, n bytes high first with ack bits, stop
    task automatic i2c_msg(input logic [31:0] m, input int n,
            output logic [3:0] acks);
        logic g;
        acks = 4'h0;
        sdaLow = 1;
        #250 sclLine = 0;
        repeat (n) begin
            repeat (8) begin
                i2c_bit(m[31], g);
                m = m << 1;
            end
            i2c_bit(1'b1, g);
            acks = {acks[2:0], !g};
        end
        sdaLow = 1;
        #250 sclLine = 1;
        #250 sdaLow = 0;
        #500;
    endtask : i2c_msg
endmodule : mgmt_host_model

// ==== bench/serial_mgmt_monitor.sv ====
// Port assertions for the serial management slave.
// Bound to the slave; strap held steady around reset.
`timescale 1ns/1ps
module serial_mgmt_monitor import serial_mgmt_pkg::*; (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic [1:0] modeStrap, // Strap pins
    input wire logic chipSelectLow, // SPI select
    input wire logic serialOutEn, // SPI out enable
    input wire logic i2cSdaOut, // SDA drive
    input wire logic i2cSdaOe, // SDA enable
    input wire logic regReq, // Access strobe
    input wire logic regWrite, // Write flag
    input wire serial_mgmt_pkg::mgmt_mode_e modeActive // Mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    mode_capture_a: assert property (
        $fell(rst) |-> ##[2:8] modeActive == modeStrap) else $error("mode");
    mode_hold_a: assert property (
        modeActive != MODE_NONE |=> $stable(modeActive)) else $error("hold");
    out_release_a: assert property (
        chipSelectLow |-> !serialOutEn) else $error("release");
    out_drive_a: assert property (
        !chipSelectLow && modeActive == MODE_SPI |-> serialOutEn)
        else $error("drive");
    spi_idle_a: assert property (
        modeActive != MODE_SPI |-> !serialOutEn) else $error("spi idle");
    ack_mode_a: assert property (
        modeActive != MODE_I2C |-> !i2cSdaOe) else $error("ack mode");
    sda_drain_a: assert property (
        i2cSdaOe |-> !i2cSdaOut) else $error("sda drive");
    req_gap_a: assert property (
        regReq |=> !regReq [*8]) else $error("req gap");
    cover property (regReq && regWrite);
    cover property (regReq && !regWrite);
    cover property (i2cSdaOe);
endmodule : serial_mgmt_monitor
bind serial_register_access_slave serial_mgmt_monitor serial_mgmt_monitor_i (
    .clk, .rst, .modeStrap, .chipSelectLow, .serialOutEn, .i2cSdaOut,
    .i2cSdaOe, .regReq, .regWrite, .modeActive);

// ==== bench/tb_serial_register_access_slave.sv ====
// Bench for the serial management slave: SPI and I2C access.
// A byte array stands for the register space behind the slave.
`timescale 1ns/1ps
module tb_serial_register_access_slave;
    import serial_mgmt_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic [1:0] modeStrap = 2'h0;
    reg_data_t regRdata = 8'h00;
    logic spiClk, chipSelectLow, serialInLine, serialOutLine, serialOutEn;
    logic sclLine, sdaLow, i2cSdaOe, regReq, regWrite;
    reg_addr_t regAddr;
    reg_data_t regWdata;
    mgmt_mode_e modeActive;
    reg_data_t mem [0:65535];
    int fails = 0, comparisons = 0, cyc = 0;
    logic [15:0] rd;
    logic [3:0] acks;
    initial forever #4 clk = ~clk;
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    serial_register_access_slave serial_register_access_slave_i (
        .clk, .rst, .modeStrap, .spiClk, .chipSelectLow, .serialInLine,
        .serialOutLine, .serialOutEn, .i2cSclIn(sclLine),
        .i2cSdaIn(!(sdaLow || i2cSdaOe)), .i2cSdaOut(), .i2cSdaOe,
        .regReq, .regWrite, .regAddr, .regWdata, .regRdata, .modeActive);
    mgmt_host_model mgmt_host_model_i (.spiClk, .chipSelectLow,
        .serialInLine, .serialOutLine, .sclLine, .sdaLow,
        .sdaIn(!(sdaLow || i2cSdaOe)));
    // Register space answers a read one clock later; hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (regReq === 1'b1 && regWrite === 1'b1) mem[regAddr] <= regWdata;
        if (regReq === 1'b1) regRdata <= #1 mem[regAddr];
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic reset_to(input logic [1:0] m);
        @(posedge clk) #1 rst = 1;
        modeStrap = m;
        repeat (10) @(posedge clk);
        #1 rst = 0;
        repeat (12) @(posedge clk);
    endtask : reset_to
    task automatic t_spi_burst;
        chk(modeActive, MODE_SPI);
        mgmt_host_model_i.frame({3'h2, 24'hAB1234}, 2, 16'h5AC3, rd);
        repeat (10) @(posedge clk);
        chk(mem[16'h1234], 8'h5A);
        chk(mem[16'h1235], 8'hC3);
        mgmt_host_model_i.frame({3'h3, 24'h001234}, 2, 16'h0000, rd);
        chk(rd, 16'h5AC3);
        $display("spi burst done");
    endtask : t_spi_burst
    task automatic t_spi_bad;
        mgmt_host_model_i.frame({3'h7, 24'h000040}, 1, 16'hFF00, rd);
        repeat (10) @(posedge clk);
        chk(mem[16'h0040], 8'h00);
        chk(serialOutEn, 1'b0);
        $display("spi bad command done");
    endtask : t_spi_bad
    task automatic t_i2c;
        reset_to(2'h1);
        chk(modeActive, MODE_I2C);
        mgmt_host_model_i.i2c_msg(32'hBE123477, 4, acks);
        chk(acks, 4'hF);
        chk(mem[16'h1234], 8'h77);
        mgmt_host_model_i.i2c_msg(32'hBFFF0000, 2, acks);
        chk(acks, 4'h2);
        mgmt_host_model_i.i2c_msg(32'hBC000000, 1, acks);
        chk(acks, 4'h0);
        $display("i2c done");
    endtask : t_i2c
    task automatic tally_and_finish;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        reset_to(2'h0);
        t_spi_burst();
        t_spi_bad();
        t_i2c();
        tally_and_finish();
    end
endmodule : tb_serial_register_access_slave

// ==== core/level_sync3.sv ====
// Three-stage synchroniser for slow levels coming from pins or
// another clock. A change is passed on once stages two and three agree.
`timescale 1ns/1ps
module level_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,         // Destination clock
    input wire logic rst,         // Synchronous reset, active high
    input wire logic [W-1:0] d,   // Asynchronous levels
    output logic [W-1:0] q        // Filtered, synchronous levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    // Stage one feeds stage two only; the filter looks at two and three
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q = (st_r.s3 & ~(st_r.s2 ^ st_r.s3))
            | (st_r.q & (st_r.s2 ^ st_r.s3));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
endmodule : level_sync3

// ==== core/serial_mgmt_pkg.sv ====
// Constants and types shared by the serial management slave files.
// Assumes a byte-wide register space with 16-bit addresses behind it.
package serial_mgmt_pkg;

    // Register space seen by the host
    localparam int REG_ADDR_W = 16;
    localparam int REG_DATA_W = 8;
    typedef logic [REG_ADDR_W-1:0] reg_addr_t;
    typedef logic [REG_DATA_W-1:0] reg_data_t;

    // SPI frame layout, in serial clock cycles
    localparam int SPI_CMD_BITS = 3;
    localparam int SPI_ADDR_BITS = 24;
    localparam int SPI_HDR_BITS = SPI_CMD_BITS + SPI_ADDR_BITS;
    localparam int SPI_TA_BITS = 5;
    localparam int SPI_DATA_BITS = 8;
    typedef logic [5:0] spi_cnt_t;
    localparam spi_cnt_t SPI_HDR_LAST = spi_cnt_t'(SPI_HDR_BITS - 1);
    localparam spi_cnt_t SPI_TA_END = spi_cnt_t'(SPI_HDR_BITS + SPI_TA_BITS);
    localparam spi_cnt_t SPI_DATA_FIRST = spi_cnt_t'(SPI_HDR_BITS
        + SPI_TA_BITS + 1);
    localparam spi_cnt_t SPI_DATA_LAST = spi_cnt_t'(SPI_HDR_BITS
        + SPI_TA_BITS + SPI_DATA_BITS);
    localparam logic [2:0] SPI_CMD_READ = 3'h3;
    localparam logic [2:0] SPI_CMD_WRITE = 3'h2;

    // I2C slave identity and byte framing
    localparam logic [6:0] I2C_DEV_ADDR = 7'h5F;
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

    // Cycles waited after reset before the strap is trusted
    localparam logic [2:0] STRAP_SETTLE = 3'h4;

    typedef enum logic [1:0] {
        MODE_SPI = 2'h0,
        MODE_I2C = 2'h1,
        MODE_PHY = 2'h2,
        MODE_NONE = 2'h3
    } mgmt_mode_e;

    typedef enum logic [2:0] {
        I_IDLE = 3'h0,
        I_RX = 3'h1,
        I_RXACK = 3'h3,
        I_TX = 3'h2,
        I_TXACK = 3'h6
    } i2c_state_e;

    typedef enum logic [1:0] {
        PH_DEV = 2'h0,
        PH_AHI = 2'h1,
        PH_ALO = 2'h2,
        PH_DATA = 2'h3
    } i2c_phase_e;

    // Burst address step, wraps at the top of the space
    function automatic reg_addr_t next_addr(input reg_addr_t a);
        next_addr = a + 16'h0001;
    endfunction : next_addr

endpackage : serial_mgmt_pkg

// ==== core/serial_register_access_slave.sv ====
// Serial management slave: SPI or I2C access to a byte register space.
// Assumes the register space answers a read one clock after the request.
//
// Notes on behaviour
// RL1 - Access mode comes from a strap captured after reset release.
// RL2 - SPI mode reads and writes every register in the space.
// RL3 - Master drives serial clock, select and input data line.
// RL4 - Only this device drives the SPI output data line.
// RL5 - Master keeps the serial clock low between transactions.
// RL6 - Select low starts a transaction; select high drops all state.
// RL7 - Access is 27 header bits, 5 turnaround bits, 8 data bits.
// RL8 - Burst: each further 8 clocks bumps the address, moves next byte.
// RL9 - Command, address and data travel MSB first on both lines.
// RL10 - Input line is captured on serial clock rising edges.
// RL11 - Output line changes on serial clock falling edges.
// RL12 - Command 011 reads, 010 writes, then a 24-bit address.
// RL13 - Only the low 16 address bits are decoded.
// RL14 - Input values during the turnaround clocks are ignored.
// RL15 - I2C slave mode gives access to all registers and tables.
// RL16 - I2C answers only the fixed address 1011_111.
// RL17 - Direction bit is the address byte LSB, one for read.
// RL18 - I2C uses 16-bit register addresses and one-byte transfers.
// RL19 - Always a slave; serial clocks are inputs only.
// RL20 - Keeps working during global soft power-down.
// RL21 - I2C write: device byte, address high, low, then data bytes.
// RL22 - SPI output is released while select is high.
`timescale 1ns/1ps
module serial_register_access_slave (
    input wire logic clk,                           // Core clock
    input wire logic rst,                           // Reset, high; sync for core side, async for SPI side
    input wire logic [1:0] modeStrap,               // Mode strap pins
    input wire logic spiClk,                        // SPI serial clock
    input wire logic chipSelectLow,                 // SPI select, low
    input wire logic serialInLine,                  // SPI data in
    output logic serialOutLine,                     // SPI data out
    output logic serialOutEn,                       // SPI out enable
    input wire logic i2cSclIn,                      // I2C clock level
    input wire logic i2cSdaIn,                      // I2C data level
    output logic i2cSdaOut,                         // I2C data drive
    output logic i2cSdaOe,                          // I2C pull-low enable
    output logic regReq,                            // Access strobe
    output logic regWrite,                          // Access is a write
    output serial_mgmt_pkg::reg_addr_t regAddr,     // Register address
    output serial_mgmt_pkg::reg_data_t regWdata,    // Write data
    input wire serial_mgmt_pkg::reg_data_t regRdata, // Read data
    output serial_mgmt_pkg::mgmt_mode_e modeActive  // Captured mode
);
    import serial_mgmt_pkg::*;

    // ------------------------------------------------------------------
    // State of the serial clock domain
    // ------------------------------------------------------------------
    typedef struct packed {
        spi_cnt_t cnt;
        logic [SPI_HDR_BITS-2:0] shift;
        logic cmdRead;
        logic cmdOk;
        reg_addr_t addr;
        logic reqTgl;
        logic reqWrite;
        reg_addr_t reqAddr;
        reg_data_t reqData;
    } spi_s;

    localparam spi_s SPI_RESET = '{
        cnt: 6'h00,
        shift: 26'h0000000,
        cmdRead: 1'b0,
        cmdOk: 1'b0,
        addr: 16'h0000,
        reqTgl: 1'b0,
        reqWrite: 1'b0,
        reqAddr: 16'h0000,
        reqData: 8'h00
    };

    // ------------------------------------------------------------------
    // State of the core clock domain
    // ------------------------------------------------------------------
    typedef struct packed {
        mgmt_mode_e mode;
        logic strapDone;
        logic [2:0] settle;
        logic spiTglSeen;
        logic reqPulse;
        logic reqWrite;
        reg_addr_t reqAddr;
        reg_data_t reqData;
        logic rdPend;
        reg_data_t rdHold;
        i2c_state_e ist;
        logic [3:0] icnt;
        i2c_phase_e phase;
        logic iRead;
        logic ackOk;
        reg_data_t ish;
        reg_addr_t iaddr;
        logic sdaLow;
        logic sclPrev;
        logic sdaPrev;
    } core_s;

    localparam core_s CORE_RESET = '{
        mode: MODE_NONE,
        strapDone: 1'b0,
        settle: 3'h0,
        spiTglSeen: 1'b0,
        reqPulse: 1'b0,
        reqWrite: 1'b0,
        reqAddr: 16'h0000,
        reqData: 8'h00,
        rdPend: 1'b0,
        rdHold: 8'h00,
        ist: I_IDLE,
        icnt: 4'h0,
        phase: PH_DEV,
        iRead: 1'b0,
        ackOk: 1'b0,
        ish: 8'h00,
        iaddr: 16'h0000,
        sdaLow: 1'b0,
        sclPrev: 1'b1,
        sdaPrev: 1'b1
    };

    spi_s sp_r;
    spi_s sp_nxt;
    core_s cs_r;
    core_s cs_nxt;
    spi_s spCur;
    logic [SPI_HDR_BITS-1:0] hdr;
    logic [1:0] strapSync;
    logic spiTglSync;
    logic sclSync;
    logic sdaSync;
    logic sclRise;
    logic sclFall;
    logic i2cStart;
    logic i2cStop;

    spi_out_if outBus ();

    // ------------------------------------------------------------------
    // SPI receive side, on the rising serial clock edge
    // ------------------------------------------------------------------
    // The first rising edge of a frame comes before any falling edge,
    // so the shifter's fresh flag marks it; this needs an idle-low clock.
    always_comb begin
        spCur = sp_r;
        if (outBus.frameFresh) begin
            spCur.cnt = 6'h00; // RL5
            spCur.cmdRead = 1'b0;
            spCur.cmdOk = 1'b0;
        end
        hdr = {spCur.shift, serialInLine}; // RL10
        sp_nxt = spCur;
        sp_nxt.shift = hdr[SPI_HDR_BITS-2:0]; // RL9
        if (spCur.cnt == SPI_DATA_LAST) begin
            sp_nxt.cnt = SPI_DATA_FIRST; // RL8
        end else begin
            sp_nxt.cnt = spCur.cnt + 6'h01;
        end
        // Command and address are complete on the 27th bit
        if (spCur.cnt == SPI_HDR_LAST) begin
            sp_nxt.cmdRead = (hdr[26:24] == SPI_CMD_READ); // RL12
            sp_nxt.cmdOk = (hdr[26:24] == SPI_CMD_READ)
                || (hdr[26:24] == SPI_CMD_WRITE); // RL12
            sp_nxt.addr = hdr[REG_ADDR_W-1:0]; // RL13
            if (hdr[26:24] == SPI_CMD_READ) begin
                sp_nxt.reqTgl = ~spCur.reqTgl; // RL2
                sp_nxt.reqWrite = 1'b0;
                sp_nxt.reqAddr = hdr[REG_ADDR_W-1:0];
            end
        end
        // Read: prefetch the following byte as each byte starts out
        if (spCur.cmdOk && spCur.cmdRead
            && sp_nxt.cnt == SPI_DATA_FIRST) begin
            sp_nxt.addr = next_addr(spCur.addr); // RL8
            sp_nxt.reqTgl = ~spCur.reqTgl;
            sp_nxt.reqWrite = 1'b0;
            sp_nxt.reqAddr = next_addr(spCur.addr);
        end
        // Write: the 8th data bit completes a byte
        if (spCur.cmdOk && !spCur.cmdRead
            && spCur.cnt == SPI_DATA_LAST - 6'h01) begin
            sp_nxt.reqTgl = ~spCur.reqTgl; // RL2
            sp_nxt.reqWrite = 1'b1;
            sp_nxt.reqAddr = spCur.addr;
            sp_nxt.reqData = hdr[REG_DATA_W-1:0]; // RL7
            sp_nxt.addr = next_addr(spCur.addr); // RL8
        end
        // Turnaround bits only advance the count and are never used
    end // RL14

    // The serial clock is still at reset, so the core reset holds it
    always_ff @(posedge spiClk or posedge rst) begin
        if (rst) begin
            sp_r <= SPI_RESET;
        end else begin
            sp_r <= sp_nxt;
        end
    end

    // Shifter reload points: end of turnaround, then every 8 clocks
    assign outBus.load = sp_r.cmdOk && sp_r.cmdRead && !outBus.frameFresh
        && (sp_r.cnt == SPI_TA_END || sp_r.cnt == SPI_DATA_LAST); // RL7
    // Read data is a held byte; the request toggle precedes each use
    // by at least five serial clocks, so it is stable when loaded.
    assign outBus.byteIn = cs_r.rdHold;

    spi_out_shifter u_shifter (
        .spiClk(spiClk),
        .chipSelectLow(chipSelectLow),
        .port(outBus)
    );

    // ------------------------------------------------------------------
    // Crossing into the core clock
    // ------------------------------------------------------------------
    level_sync3 #(
        .W(5)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({modeStrap, sp_r.reqTgl, i2cSclIn, i2cSdaIn}),
        .q({strapSync, spiTglSync, sclSync, sdaSync})
    );

    // I2C bus events; start and stop are data edges while clock is high
    assign sclRise = sclSync && !cs_r.sclPrev;
    assign sclFall = !sclSync && cs_r.sclPrev;
    assign i2cStart = sclSync && cs_r.sclPrev && cs_r.sdaPrev && !sdaSync;
    assign i2cStop = sclSync && cs_r.sclPrev && !cs_r.sdaPrev && sdaSync;

    // ------------------------------------------------------------------
    // Core side: strap, access port, I2C slave
    // ------------------------------------------------------------------
    // Nothing here looks at power-down state: the slave stays live.
    always_comb begin
        cs_nxt = cs_r; // RL20
        cs_nxt.reqPulse = 1'b0;
        cs_nxt.sclPrev = sclSync;
        cs_nxt.sdaPrev = sdaSync;
        cs_nxt.rdPend = cs_r.reqPulse && !cs_r.reqWrite;
        if (cs_r.rdPend) begin
            cs_nxt.rdHold = regRdata;
        end
        // Strap waits out the synchroniser before being taken once
        if (!cs_r.strapDone) begin
            cs_nxt.settle = cs_r.settle + 3'h1;
            if (cs_r.settle == STRAP_SETTLE) begin
                cs_nxt.strapDone = 1'b1;
                cs_nxt.mode = mgmt_mode_e'(strapSync); // RL1
            end
        end
        // SPI request arrives as a toggle; fields are stable by then
        if (spiTglSync != cs_r.spiTglSeen) begin
            cs_nxt.spiTglSeen = spiTglSync;
            if (cs_r.mode == MODE_SPI) begin
                cs_nxt.reqPulse = 1'b1; // RL2
                cs_nxt.reqWrite = sp_r.reqWrite;
                cs_nxt.reqAddr = sp_r.reqAddr;
                cs_nxt.reqData = sp_r.reqData;
            end
        end
        // I2C slave, sampling the synchronised bus lines
        if (cs_r.mode != MODE_I2C || i2cStop) begin
            cs_nxt.ist = I_IDLE;
            cs_nxt.sdaLow = 1'b0;
        end else if (i2cStart) begin
            cs_nxt.ist = I_RX;
            cs_nxt.icnt = 4'h0;
            cs_nxt.phase = PH_DEV;
            cs_nxt.sdaLow = 1'b0;
        end else begin
            unique case (cs_r.ist)
                I_IDLE: begin
                    cs_nxt.icnt = 4'h0;
                end
                I_RX: begin
                    if (sclRise && cs_r.icnt != I2C_BYTE_BITS) begin
                        cs_nxt.ish = {cs_r.ish[6:0], sdaSync};
                        cs_nxt.icnt = cs_r.icnt + 4'h1;
                    end else if (sclFall
                        && cs_r.icnt == I2C_BYTE_BITS) begin
                        cs_nxt.icnt = 4'h0;
                        cs_nxt.ist = I_RXACK;
                        cs_nxt.sdaLow = 1'b1;
                        unique case (cs_r.phase)
                            PH_DEV: begin
                                if (cs_r.ish[7:1] == I2C_DEV_ADDR) begin
                                    cs_nxt.iRead = cs_r.ish[0]; // RL17
                                    cs_nxt.phase = PH_AHI;
                                    if (cs_r.ish[0]) begin
                                        cs_nxt.reqPulse = 1'b1; // RL15
                                        cs_nxt.reqWrite = 1'b0;
                                        cs_nxt.reqAddr = cs_r.iaddr;
                                    end
                                end else begin
                                    cs_nxt.ist = I_IDLE; // RL16
                                    cs_nxt.sdaLow = 1'b0;
                                end
                            end
                            PH_AHI: begin
                                cs_nxt.iaddr[15:8] = cs_r.ish; // RL21
                                cs_nxt.phase = PH_ALO;
                            end
                            PH_ALO: begin
                                cs_nxt.iaddr[7:0] = cs_r.ish; // RL18
                                cs_nxt.phase = PH_DATA;
                            end
                            PH_DATA: begin
                                cs_nxt.reqPulse = 1'b1; // RL15
                                cs_nxt.reqWrite = 1'b1;
                                cs_nxt.reqAddr = cs_r.iaddr;
                                cs_nxt.reqData = cs_r.ish; // RL18
                                cs_nxt.iaddr = next_addr(cs_r.iaddr); // RL21
                            end
                        endcase
                    end
                end
                I_RXACK: begin
                    if (sclFall) begin
                        cs_nxt.sdaLow = 1'b0;
                        if (cs_r.iRead) begin
                            cs_nxt.ist = I_TX;
                            cs_nxt.ish = cs_r.rdHold;
                            cs_nxt.sdaLow = !cs_r.rdHold[7];
                        end else begin
                            cs_nxt.ist = I_RX;
                        end
                    end
                end
                I_TX: begin
                    if (sclFall) begin
                        if (cs_r.icnt == I2C_BYTE_BITS - 4'h1) begin
                            cs_nxt.icnt = 4'h0;
                            cs_nxt.sdaLow = 1'b0;
                            cs_nxt.ist = I_TXACK;
                        end else begin
                            cs_nxt.ish = {cs_r.ish[6:0], 1'b0};
                            cs_nxt.sdaLow = !cs_r.ish[6];
                            cs_nxt.icnt = cs_r.icnt + 4'h1;
                        end
                    end
                end
                I_TXACK: begin
                    // Master ack asks for the next byte; fetch it now
                    if (sclRise) begin
                        cs_nxt.ackOk = !sdaSync;
                        if (!sdaSync) begin
                            cs_nxt.iaddr = next_addr(cs_r.iaddr);
                            cs_nxt.reqPulse = 1'b1;
                            cs_nxt.reqWrite = 1'b0;
                            cs_nxt.reqAddr = next_addr(cs_r.iaddr);
                        end
                    end else if (sclFall) begin
                        if (cs_r.ackOk) begin
                            cs_nxt.ist = I_TX;
                            cs_nxt.ish = cs_r.rdHold;
                            cs_nxt.sdaLow = !cs_r.rdHold[7];
                        end else begin
                            cs_nxt.ist = I_IDLE;
                        end
                    end
                end
                default: begin
                    cs_nxt.ist = I_IDLE;
                    cs_nxt.sdaLow = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_r <= CORE_RESET;
        end else begin
            cs_r <= cs_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Data line is driven only in SPI mode and inside a frame
    assign serialOutLine = outBus.outBit; // RL4
    assign serialOutEn = !chipSelectLow && (cs_r.mode == MODE_SPI); // RL22
    // Open drain: only ever pull low; both clocks are inputs
    assign i2cSdaOut = 1'b0; // RL19
    assign i2cSdaOe = cs_r.sdaLow;
    assign regReq = cs_r.reqPulse;
    assign regWrite = cs_r.reqWrite;
    assign regAddr = cs_r.reqAddr;
    assign regWdata = cs_r.reqData;
    assign modeActive = cs_r.mode;
endmodule : serial_register_access_slave

// ==== core/spi_out_if.sv ====
// Carrier between the SPI receive logic and the output shifter.
// Load and fresh flag sit on opposite serial clock edges; the byte comes from the core clock.
`timescale 1ns/1ps
interface spi_out_if;
    logic load;
    serial_mgmt_pkg::reg_data_t byteIn;
    logic outBit;
    logic frameFresh;

    modport core (output load, output byteIn, input outBit,
        input frameFresh);
    modport shifter (input load, input byteIn, output outBit,
        output frameFresh);
endinterface : spi_out_if

// ==== core/spi_out_shifter.sv ====
// Falling-edge output shifter for the SPI data line.
// Assumes the serial clock idles low and the select resets it.
`timescale 1ns/1ps
module spi_out_shifter (
    input wire logic spiClk,          // Serial clock from the master
    input wire logic chipSelectLow,   // Select, high clears the shifter
    spi_out_if.shifter port           // Load strobe, byte, output bit
);
    import serial_mgmt_pkg::*;

    typedef struct packed {
        reg_data_t sr;
        logic fresh;
    } shift_s;

    shift_s st_r;
    shift_s st_nxt;

    // Output changes only on falling edges, MSB first
    always_comb begin
        st_nxt = st_r;
        st_nxt.fresh = 1'b0;
        if (port.load) begin
            st_nxt.sr = port.byteIn; // RL11
        end else begin
            st_nxt.sr = {st_r.sr[6:0], 1'b0}; // RL9
        end
    end

    // Fresh stays set until the first falling edge of a frame
    always_ff @(negedge spiClk or posedge chipSelectLow) begin
        if (chipSelectLow) begin
            st_r <= '{sr: 8'h00, fresh: 1'b1}; // RL6
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port.outBit = st_r.sr[7];
    assign port.frameFresh = st_r.fresh;
endmodule : spi_out_shifter
